// >>> design/upfp_ctl.sv
// usb controller end: emulated fifos, flags and 60 MHz port clock
`timescale 1ns/1ps
module upfp_ctl (
    // link side
    upfp_if.ctl lnk,
    // link clock from the controller's own oscillator
    input wire logic linkClk,
    input wire logic linkRst,
    // host side, linkClk domain
    input wire logic syncMode,
    input wire logic suspended,
    input wire logic serialActive,
    input wire logic [7:0] hostTxData,
    input wire logic hostTxValid,
    output logic hostTxReady,
    output logic [7:0] hostRxData,
    output logic hostRxValid,
    input wire logic hostRxReady,
    output logic flushReq,
    output logic wakeReq
);
    // --------------------------------------------------------------------------------
    // storage: to-user and from-user queues
    // --------------------------------------------------------------------------------
    logic [7:0] toUsr [upfp_pkg::DEPTH];
    logic [7:0] fromUsr [upfp_pkg::DEPTH];
    logic [upfp_pkg::PTR_W-1:0] tuWp_r, tuWp_nxt, tuRp_r, tuRp_nxt;
    logic [upfp_pkg::PTR_W-1:0] fuWp_r, fuWp_nxt, fuRp_r, fuRp_nxt;
    logic [upfp_pkg::CNT_W-1:0] tuCnt_r, tuCnt_nxt, fuCnt_r, fuCnt_nxt;
    logic [7:0] dOut_r, dOut_nxt;
    // strobe pins {send, oe, wr, rd}: three stages, then a filtered copy
    logic [3:0] pinS1_r, pinS2_r, pinS3_r, pinF_r, pinF_nxt;
    logic [7:0] datS1_r, datS2_r, datS3_r;
    logic rxAvail_n_r, rxAvail_n_nxt, txSpace_n_r, txSpace_n_nxt;
    logic flush_r, flush_nxt, wake_r, wake_nxt;
    logic tuPush, tuPop, fuPush, fuPop, rdFall, wrRise, wrFall, siFall, portOn;

    // user strobes come from another clock; a change counts once stages 2 and 3
    // agree, and each strobe moves one byte however many edges it spans
    always_comb begin
        portOn = !serialActive;
        pinF_nxt = (~(pinS2_r ^ pinS3_r) & pinS3_r) | ((pinS2_r ^ pinS3_r) & pinF_r);
        rdFall = portOn && pinF_r[0] && !pinF_nxt[0] && tuCnt_r != '0;
        wrRise = portOn && !pinF_r[1] && pinF_nxt[1] && fuCnt_r != upfp_pkg::FIFO_DEPTH;
        wrFall = portOn && pinF_r[1] && !pinF_nxt[1] && fuCnt_r != upfp_pkg::FIFO_DEPTH;
        if (syncMode) begin
            rdFall = rdFall && !pinF_nxt[2];
            wrRise = wrFall;
        end
        siFall = pinF_r[3] && !pinF_nxt[3];
        tuPush = hostTxValid && tuCnt_r != upfp_pkg::FIFO_DEPTH;
        tuPop = rdFall;
        fuPush = wrRise;
        fuPop = hostRxReady && fuCnt_r != '0;
        tuWp_nxt = tuPush ? tuWp_r + 1'b1 : tuWp_r;
        tuRp_nxt = tuPop ? tuRp_r + 1'b1 : tuRp_r;
        fuWp_nxt = fuPush ? fuWp_r + 1'b1 : fuWp_r;
        fuRp_nxt = fuPop ? fuRp_r + 1'b1 : fuRp_r;
        tuCnt_nxt = tuCnt_r + upfp_pkg::CNT_W'(tuPush) - upfp_pkg::CNT_W'(tuPop);
        fuCnt_nxt = fuCnt_r + upfp_pkg::CNT_W'(fuPush) - upfp_pkg::CNT_W'(fuPop);
        dOut_nxt = tuPop ? toUsr[tuRp_r] : dOut_r;
        rxAvail_n_nxt = !(portOn && tuCnt_nxt != '0);
        txSpace_n_nxt = !(portOn && fuCnt_nxt != upfp_pkg::FIFO_DEPTH);
        flush_nxt = siFall && !suspended;
        wake_nxt = siFall && suspended;
    end

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            tuWp_r <= '0;
            tuRp_r <= '0;
            fuWp_r <= '0;
            fuRp_r <= '0;
            tuCnt_r <= '0;
            fuCnt_r <= '0;
            dOut_r <= upfp_pkg::DATA_RST;
            pinS1_r <= 4'hf;
            pinS2_r <= 4'hf;
            pinS3_r <= 4'hf;
            pinF_r <= 4'hf;
            datS1_r <= upfp_pkg::DATA_RST;
            datS2_r <= upfp_pkg::DATA_RST;
            datS3_r <= upfp_pkg::DATA_RST;
            rxAvail_n_r <= 1'b1;
            txSpace_n_r <= 1'b0;
            flush_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            tuWp_r <= tuWp_nxt;
            tuRp_r <= tuRp_nxt;
            fuWp_r <= fuWp_nxt;
            fuRp_r <= fuRp_nxt;
            tuCnt_r <= tuCnt_nxt;
            fuCnt_r <= fuCnt_nxt;
            dOut_r <= dOut_nxt;
            pinS1_r <= {lnk.sendNowWake_n, lnk.oe_n, lnk.wr_n, lnk.rd_n};
            pinS2_r <= pinS1_r;
            pinS3_r <= pinS2_r;
            pinF_r <= pinF_nxt;
            datS1_r <= lnk.dataUsr;
            datS2_r <= datS1_r;
            datS3_r <= datS2_r;
            rxAvail_n_r <= rxAvail_n_nxt;
            txSpace_n_r <= txSpace_n_nxt;
            flush_r <= flush_nxt;
            wake_r <= wake_nxt;
        end
    end

    always_ff @(posedge linkClk) begin
        if (tuPush) begin
            toUsr[tuWp_r] <= hostTxData;
        end
        if (fuPush) begin
            fromUsr[fuWp_r] <= datS3_r;
        end
    end

    // --------------------------------------------------------------------------------
    // pins
    // --------------------------------------------------------------------------------
    assign lnk.portClock60m = linkClk;
    assign lnk.dataCtl = dOut_r;
    assign lnk.dataCtlOe_n = !(portOn && !lnk.oe_n);
    assign lnk.rxAvail_n = rxAvail_n_r;
    assign lnk.txSpace_n = txSpace_n_r;
    assign hostTxReady = tuCnt_r != upfp_pkg::FIFO_DEPTH;
    assign hostRxData = fromUsr[fuRp_r];
    assign hostRxValid = fuCnt_r != '0;
    assign flushReq = flush_r;
    assign wakeReq = wake_r;
endmodule : upfp_ctl

// >>> design/upfp_if.sv
// pin bundle between the usb controller end and the user logic end
`timescale 1ns/1ps
interface upfp_if;
    logic portClock60m;
    logic [7:0] dataCtl;
    logic dataCtlOe_n;
    logic [7:0] dataUsr;
    logic dataUsrOe_n;
    logic rxAvail_n;
    logic txSpace_n;
    logic rd_n;
    logic wr_n;
    logic oe_n;
    logic sendNowWake_n;

    modport ctl (
        output portClock60m, dataCtl, dataCtlOe_n, rxAvail_n, txSpace_n,
        input dataUsr, dataUsrOe_n, rd_n, wr_n, oe_n, sendNowWake_n
    );
    modport usr (
        input portClock60m, dataCtl, dataCtlOe_n, rxAvail_n, txSpace_n,
        output dataUsr, dataUsrOe_n, rd_n, wr_n, oe_n, sendNowWake_n
    );
endinterface : upfp_if

// >>> design/upfp_pkg.sv
// shared constants and types for the byte-wide fifo transfer port
// --------------------------------------------------------------------------------
// Operation
// - one byte per transfer, 8-bit bidirectional bus
// - software selects synchronous or asynchronous mode
// - sync mode: controller outputs 60 MHz clock
// - async mode: strobes alone pace transfers
// - rx_avail_n low while bytes wait
// - tx_space_n low while space exists
// - low read strobe presents next byte
// - low write strobe stores bus byte
// - oe low: controller drives; high: user drives
// - send_now pulse flushes partial packet
// - send_now pulse wakes suspended host
// - parallel and serial ports never both active
// --------------------------------------------------------------------------------
package upfp_pkg;
    localparam int DATA_W = 8;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FIFO_DEPTH = 5'h10;
    // link and user clock figures
    localparam int LINK_CLK_MHZ = 60;
    localparam int MCLK_MHZ = 100;
    // user end builds the async strobe from mclk; strobe low time in ns.
    // long enough for the controller's pin filter to see two samples and
    // for the popped byte to cross back before the strobe ends
    localparam int STROBE_NS = 200;
    localparam int STROBE_CYC = (STROBE_NS * MCLK_MHZ + 999) / 1000;
    localparam logic [4:0] STROBE_CNT = 5'(STROBE_CYC);
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [2:0] {
        UPFP_IDLE = 3'b000,
        UPFP_OE = 3'b001,
        UPFP_RDLOW = 3'b011,
        UPFP_RDHIGH = 3'b010,
        UPFP_WRLOW = 3'b110,
        UPFP_WRHIGH = 3'b111
    } upfp_state_t;
endpackage : upfp_pkg

// >>> design/upfp_usr.sv
// user logic end: reads and writes bytes through the fifo port
`timescale 1ns/1ps
module upfp_usr (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // link side
    upfp_if.usr lnk,
    // user side, mclk domain
    input wire logic syncMode,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    input wire logic sendNow,
    output logic sendNowBusy
);
    // --------------------------------------------------------------------------------
    // flag synchronisers: three stages, change counts once stages 2 and 3 agree
    // --------------------------------------------------------------------------------
    logic [2:0] rxfSync_r, rxfSync_nxt, txeSync_r, txeSync_nxt;
    logic rxAvail_r, rxAvail_nxt, txSpace_r, txSpace_nxt;
    logic [7:0] dcSync1_r, dcSync2_r, dcSync3_r;

    always_comb begin
        rxfSync_nxt = {rxfSync_r[1:0], !lnk.rxAvail_n};
        txeSync_nxt = {txeSync_r[1:0], !lnk.txSpace_n};
        rxAvail_nxt = (rxfSync_r[2] == rxfSync_r[1]) ? rxfSync_r[2] : rxAvail_r;
        txSpace_nxt = (txeSync_r[2] == txeSync_r[1]) ? txeSync_r[2] : txSpace_r;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rxfSync_r <= '0;
            txeSync_r <= '0;
            rxAvail_r <= 1'b0;
            txSpace_r <= 1'b0;
            dcSync1_r <= '0;
            dcSync2_r <= '0;
            dcSync3_r <= '0;
        end else begin
            rxfSync_r <= rxfSync_nxt;
            txeSync_r <= txeSync_nxt;
            rxAvail_r <= rxAvail_nxt;
            txSpace_r <= txSpace_nxt;
            // data only moves early in the held strobe, long before it is taken
            dcSync1_r <= lnk.dataCtl;
            dcSync2_r <= dcSync1_r;
            dcSync3_r <= dcSync2_r;
        end
    end

    // --------------------------------------------------------------------------------
    // strobe sequencer; the async timing is used in both modes for simplicity,
    // so sync mode runs at async speed
    // --------------------------------------------------------------------------------
    upfp_pkg::upfp_state_t st_r, st_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt, oe_r, oe_nxt, drv_r, drv_nxt;
    logic [7:0] dout_r, dout_nxt, rxd_r, rxd_nxt;
    logic rxv_r, rxv_nxt, txr_r, txr_nxt;
    logic si_r, si_nxt;
    logic [4:0] siCnt_r, siCnt_nxt;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = (cnt_r != '0) ? cnt_r - 5'h01 : cnt_r;
        rd_nxt = rd_r;
        wr_nxt = wr_r;
        oe_nxt = oe_r;
        drv_nxt = drv_r;
        dout_nxt = dout_r;
        rxd_nxt = rxd_r;
        rxv_nxt = rxv_r && !rxReady;
        txr_nxt = 1'b0;
        case (st_r)
            upfp_pkg::UPFP_IDLE: begin
                if (rxAvail_r && !rxv_r) begin
                    drv_nxt = 1'b0;
                    st_nxt = upfp_pkg::UPFP_OE;
                    cnt_nxt = upfp_pkg::STROBE_CNT;
                end else if (txSpace_r && txValid) begin
                    dout_nxt = txData;
                    drv_nxt = 1'b1;
                    txr_nxt = 1'b1;
                    wr_nxt = 1'b0;
                    st_nxt = upfp_pkg::UPFP_WRLOW;
                    cnt_nxt = upfp_pkg::STROBE_CNT;
                end
            end
            upfp_pkg::UPFP_OE: begin
                if (cnt_r == '0) begin
                    oe_nxt = 1'b0;
                    rd_nxt = 1'b0;
                    st_nxt = upfp_pkg::UPFP_RDLOW;
                    cnt_nxt = upfp_pkg::STROBE_CNT;
                end
            end
            upfp_pkg::UPFP_RDLOW: begin
                if (cnt_r == '0) begin
                    rxd_nxt = dcSync3_r;
                    rxv_nxt = 1'b1;
                    rd_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    st_nxt = upfp_pkg::UPFP_RDHIGH;
                    cnt_nxt = upfp_pkg::STROBE_CNT;
                end
            end
            upfp_pkg::UPFP_RDHIGH: begin
                if (cnt_r == '0) begin
                    st_nxt = upfp_pkg::UPFP_IDLE;
                end
            end
            upfp_pkg::UPFP_WRLOW: begin
                if (cnt_r == '0) begin
                    wr_nxt = 1'b1;
                    st_nxt = upfp_pkg::UPFP_WRHIGH;
                    cnt_nxt = upfp_pkg::STROBE_CNT;
                end
            end
            upfp_pkg::UPFP_WRHIGH: begin
                if (cnt_r == '0) begin
                    st_nxt = upfp_pkg::UPFP_IDLE;
                end
            end
            default: begin
                st_nxt = upfp_pkg::UPFP_IDLE;
            end
        endcase
        // send-immediate / wake pulse, held long enough to be seen
        si_nxt = si_r;
        siCnt_nxt = (siCnt_r != '0) ? siCnt_r - 5'h01 : siCnt_r;
        if (sendNow && !si_r) begin
            si_nxt = 1'b1;
            siCnt_nxt = upfp_pkg::STROBE_CNT;
        end else if (si_r && siCnt_r == '0) begin
            si_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= upfp_pkg::UPFP_IDLE;
            cnt_r <= '0;
            rd_r <= 1'b1;
            wr_r <= 1'b1;
            oe_r <= 1'b1;
            drv_r <= 1'b0;
            dout_r <= upfp_pkg::DATA_RST;
            rxd_r <= upfp_pkg::DATA_RST;
            rxv_r <= 1'b0;
            txr_r <= 1'b0;
            si_r <= 1'b0;
            siCnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            oe_r <= oe_nxt;
            drv_r <= drv_nxt;
            dout_r <= dout_nxt;
            rxd_r <= rxd_nxt;
            rxv_r <= rxv_nxt;
            txr_r <= txr_nxt;
            si_r <= si_nxt;
            siCnt_r <= siCnt_nxt;
        end
    end

    assign lnk.rd_n = rd_r;
    assign lnk.wr_n = wr_r;
    assign lnk.oe_n = oe_r;
    assign lnk.dataUsr = dout_r;
    assign lnk.dataUsrOe_n = !drv_r;
    assign lnk.sendNowWake_n = !si_r;
    assign rxData = rxd_r;
    assign rxValid = rxv_r;
    assign txReady = txr_r;
    assign sendNowBusy = si_r;
endmodule : upfp_usr

// >>> tb/testbench.sv
// self-checking bench: both port ends joined through the pin bundle
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic linkClk = 1'b0;
    logic sys_rst = 1'b1;
    logic linkRst = 1'b1;
    logic syncMode = 1'b0;
    logic suspended = 1'b0;
    logic serialActive = 1'b0;
    logic [7:0] hostTxData = 8'h00;
    logic hostTxValid = 1'b0;
    logic hostTxReady, hostRxValid, flushReq, wakeReq, txReady, rxValid, sendNowBusy;
    logic [7:0] hostRxData, rxData;
    logic hostRxReady = 1'b1;
    logic [7:0] txData = 8'h00;
    logic txValid = 1'b0;
    logic rxReady = 1'b1;
    logic sendNow = 1'b0;
    logic [7:0] toUsr[$];
    logic [7:0] toHost[$];
    logic [31:0] seed = 32'h0000003d;
    int mismatches = 0;
    int checked = 0;
    int nFlush = 0;
    int nWake = 0;
    int nAcc = 0;

    upfp_if lnk ();
    upfp_ctl u_upfp_ctl (.lnk(lnk.ctl), .linkClk(linkClk), .linkRst(linkRst),
        .syncMode(syncMode), .suspended(suspended), .serialActive(serialActive),
        .hostTxData(hostTxData), .hostTxValid(hostTxValid), .hostTxReady(hostTxReady),
        .hostRxData(hostRxData), .hostRxValid(hostRxValid), .hostRxReady(hostRxReady),
        .flushReq(flushReq), .wakeReq(wakeReq));
    upfp_usr u_upfp_usr (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk.usr), .syncMode(syncMode),
        .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
        .rxValid(rxValid), .rxReady(rxReady), .sendNow(sendNow), .sendNowBusy(sendNowBusy));
    upfp_checker u_upfp_checker (.mclk(mclk), .sys_rst(sys_rst),
        .dataCtlOe_n(lnk.dataCtlOe_n), .dataUsrOe_n(lnk.dataUsrOe_n), .rd_n(lnk.rd_n),
        .wr_n(lnk.wr_n), .oe_n(lnk.oe_n));

    initial forever #5 mclk = ~mclk;
    // odd offset puts every fifth link clock rise on an mclk rise
    initial begin
        #3;
        forever #16 linkClk = ~linkClk;
    end

    function automatic logic [7:0] nextByte();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : nextByte

    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic fail(input string m);
        mismatches++;
        $display("CHECK FAILED at %0t: timeout %s", $time, m);
        wrap_up();
    endtask : fail

    task automatic waitFor(ref logic s, input logic v, input string m);
        int n;
        n = 0;
        while (s !== v && n < 500) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (s !== v) fail(m);
    endtask : waitFor

    task automatic hostPush(input logic [7:0] d);
        int n;
        n = 0;
        @(posedge linkClk);
        #1;
        hostTxData = d;
        hostTxValid = 1'b1;
        while (hostTxReady !== 1'b1 && n < 200) begin
            @(posedge linkClk);
            #1;
            n++;
        end
        if (hostTxReady !== 1'b1) fail("host push");
        toUsr.push_back(d);
        @(posedge linkClk);
        #1;
        hostTxValid = 1'b0;
    endtask : hostPush

    task automatic usrPush(input logic [7:0] d);
        @(posedge mclk);
        #1;
        txData = d;
        txValid = 1'b1;
        waitFor(txReady, 1'b1, "user push");
        txValid = 1'b0;
        toHost.push_back(d);
    endtask : usrPush

    task automatic drain();
        int n;
        n = 0;
        while ((toUsr.size() != 0 || toHost.size() != 0) && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (toUsr.size() != 0 || toHost.size() != 0) fail("drain");
    endtask : drain

    // -----------------------------------------
    // receivers compare against the expected streams
    // -----------------------------------------
    always @(posedge mclk) begin
        nAcc += (txReady === 1'b1);
        if (sys_rst === 1'b0 && rxValid === 1'b1 && rxReady === 1'b1) begin
            chk(toUsr.size() != 0 ? rxData === toUsr[0] : 1'b0, "byte to user");
            if (toUsr.size() != 0) void'(toUsr.pop_front());
        end
    end
    always @(posedge linkClk) begin
        nFlush += (flushReq === 1'b1);
        nWake += (wakeReq === 1'b1);
        if (linkRst === 1'b0 && hostRxValid === 1'b1 && hostRxReady === 1'b1) begin
            chk(toHost.size() != 0 ? hostRxData === toHost[0] : 1'b0, "byte to host");
            if (toHost.size() != 0) void'(toHost.pop_front());
        end
    end

    initial begin
        logic [7:0] pat [4];
        int acc;
        pat = '{8'h00, 8'hff, 8'h55, 8'haa};
        repeat (2) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        repeat (2) @(posedge linkClk);
        #1;
        linkRst = 1'b0;
        repeat (10) @(posedge mclk);
        chk(lnk.rxAvail_n === 1'b1 && lnk.txSpace_n === 1'b0, "flags after reset");
        for (int m = 0; m < 2; m++) begin
            syncMode = m[0];
            for (int i = 0; i < 6; i++) begin
                hostPush(i < 4 ? pat[i] : nextByte());
                usrPush(i < 4 ? ~pat[i] : nextByte());
            end
            drain();
        end
        // fill the host-bound side while the host stalls
        hostRxReady = 1'b0;
        for (int i = 0; i < upfp_pkg::DEPTH; i++) usrPush(nextByte());
        repeat (80) @(posedge mclk);
        chk(lnk.txSpace_n === 1'b1, "space flag when full");
        #1;
        acc = nAcc;
        txValid = 1'b1;
        repeat (40) @(posedge mclk);
        chk(nAcc == acc, "write taken while full");
        #1;
        txValid = 1'b0;
        @(posedge linkClk);
        #1;
        hostRxReady = 1'b1;
        drain();
        repeat (20) @(posedge mclk);
        chk(lnk.txSpace_n === 1'b0, "space flag after drain");
        rxReady = 1'b0;
        hostPush(nextByte());
        hostPush(nextByte());
        repeat (60) @(posedge mclk);
        chk(lnk.rxAvail_n === 1'b0, "data flag while waiting");
        #1;
        rxReady = 1'b1;
        drain();
        repeat (30) @(posedge mclk);
        chk(lnk.rxAvail_n === 1'b1, "data flag when empty");
        #1;
        serialActive = 1'b1;
        repeat (20) @(posedge mclk);
        chk(lnk.rxAvail_n === 1'b1 && lnk.txSpace_n === 1'b1, "flags in serial use");
        #1;
        serialActive = 1'b0;
        for (int s = 0; s < 2; s++) begin
            suspended = s[0];
            repeat (10) @(posedge mclk);
            #1;
            sendNow = 1'b1;
            waitFor(sendNowBusy, 1'b1, "send start");
            sendNow = 1'b0;
            waitFor(sendNowBusy, 1'b0, "send end");
            repeat (20) @(posedge mclk);
            chk(nFlush == 1 && nWake == s, "send-now outcome");
        end
        wrap_up();
    end
endmodule : testbench

// >>> tb/upfp_checker.sv
// concurrent pin checks on the fifo port, user clock domain
`timescale 1ns/1ps
module upfp_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // link pins
    input wire logic dataCtlOe_n,
    input wire logic dataUsrOe_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // -----------------------------------------
    // strobe shapes and bus ownership
    // -----------------------------------------
    // strobes are longer than a repetition can follow, so runs are counted
    localparam int STROBE_LEN = upfp_pkg::STROBE_CYC + 1;
    logic [7:0] rdLow, wrLow, rdHigh, wrHigh;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdLow <= 8'h00;
            wrLow <= 8'h00;
            rdHigh <= 8'hff;
            wrHigh <= 8'hff;
        end else begin
            rdLow <= rd_n ? 8'h00 : rdLow + 8'h01;
            wrLow <= wr_n ? 8'h00 : wrLow + 8'h01;
            rdHigh <= !rd_n ? 8'h00 : rdHigh + 8'(rdHigh != 8'hff);
            wrHigh <= !wr_n ? 8'h00 : wrHigh + 8'(wrHigh != 8'hff);
        end
    end

    sequence s_rdEnd; $rose(rd_n); endsequence
    sequence s_wrEnd; $rose(wr_n); endsequence
    sequence s_rdStart; $fell(rd_n); endsequence
    sequence s_wrStart; $fell(wr_n); endsequence

    property p_rdPulse; s_rdEnd |-> rdLow == 8'(STROBE_LEN); endproperty
    a_rdPulse:
        assert property (p_rdPulse) else $error("read strobe width wrong");
    property p_wrPulse; s_wrEnd |-> wrLow == 8'(STROBE_LEN); endproperty
    a_wrPulse:
        assert property (p_wrPulse) else $error("write strobe width wrong");
    property p_rdGap; s_rdStart |-> rdHigh >= 8'(STROBE_LEN); endproperty
    a_rdGap:
        assert property (p_rdGap) else $error("read strobe high time short");
    property p_wrGap; s_wrStart |-> wrHigh >= 8'(STROBE_LEN); endproperty
    a_wrGap:
        assert property (p_wrGap) else $error("write strobe high time short");
    property p_rdOe; !rd_n |-> !oe_n; endproperty
    a_rdOe:
        assert property (p_rdOe) else $error("read without output enable");
    property p_wrDrive; !wr_n |-> !dataUsrOe_n; endproperty
    a_wrDrive:
        assert property (p_wrDrive) else $error("write while user end not driving");
    property p_ctlOe; !dataCtlOe_n |-> !oe_n; endproperty
    a_ctlOe:
        assert property (p_ctlOe) else $error("controller drives while enable high");
    property p_noClash; dataCtlOe_n || dataUsrOe_n; endproperty
    a_noClash:
        assert property (p_noClash) else $error("both ends drive the bus");
    property p_oeRelease; $fell(oe_n) |-> $past(dataUsrOe_n); endproperty
    a_oeRelease:
        assert property (p_oeRelease) else $error("enable lowered before release");
    property p_oneXfer; rd_n || wr_n; endproperty
    a_oneXfer:
        assert property (p_oneXfer) else $error("read and write strobes together");
endmodule : upfp_checker
